// *** pkg/adc_ctrl_defines.vh ***
// Constants for the converter control block
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define OFS_MODE0 12'h000
`define OFS_MODE1 12'h004
`define OFS_MODE2 12'h008
`define OFS_CHSEL 12'h00c
`define OFS_STATUS 12'h010
`define OFS_MASK 12'h014
`define OFS_STBY 12'h018
`define OFS_RESULT 12'h040
`define OFS_RESULT_END 12'h07c
`define RES_W 10
`define NCH 16
`define CH_W 4
`define BIT_CE 0
`define BIT_CONT 1
`define BIT_SCAN 2
`define BIT_PFE 0
`define BIT_PFC 1
`define THR_LSB 8
`define ST_END 0
`define ST_INVAL 1
`define STBY_STOP 0
`define STBY_IDLE 1
`define SAMPLE_NS 32
`define CONV_NS 160
`define CLK_NS 4
`define SAMPLE_CYC ((`SAMPLE_NS + `CLK_NS - 1) / `CLK_NS)
`define CONV_CYC ((`CONV_NS + `CLK_NS - 1) / `CLK_NS)
`define DISCARD_STOP 2'h2
`define DISCARD_IDLE 2'h1
`endif

// *** src/conv_timer.v ***
// Conversion timing counter: sampling interval then hold to end
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module conv_timer (
  input wire mclk,
  input wire rst_n,
  input wire start,
  input wire abort,
  output reg sampling,
  output reg busy,
  output reg done
);
  localparam [7:0] SAMPLE_END = `SAMPLE_CYC;
  localparam [7:0] CONV_END = `CONV_CYC;
  reg [7:0] cnt_reg;
  always @(posedge mclk) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      busy <= 1'b0;
      sampling <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        sampling <= 1'b0;
        cnt_reg <= 8'h00;
      end else if (start && !busy) begin
        busy <= 1'b1;
        sampling <= 1'b1;
        cnt_reg <= 8'h01;
      end else if (busy) begin
        // Conversion time includes sampling
        if (cnt_reg == SAMPLE_END)
          sampling <= 1'b0;
        if (cnt_reg == CONV_END) begin
          busy <= 1'b0;
          done <= 1'b1;
          cnt_reg <= 8'h00;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end
endmodule // conv_timer

// *** src/result_bank.v ***
// Sixteen result words with per-channel validity
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module result_bank (
  input wire mclk,
  input wire rst_n,
  input wire wr_en,
  input wire [3:0] wr_ch,
  input wire [9:0] wr_data,
  input wire wr_valid,
  input wire [3:0] rd_ch,
  output wire [9:0] rd_data,
  output wire rd_valid
);
  reg [9:0] mem [0:15];
  reg [15:0] valid_reg;
  always @(posedge mclk) begin
    if (wr_en)
      mem[wr_ch] <= wr_data;
  end
  always @(posedge mclk) begin
    if (!rst_n)
      valid_reg <= 16'h0000;
    else if (wr_en)
      valid_reg[wr_ch] <= wr_valid;
  end
  assign rd_data = valid_reg[rd_ch] ? mem[rd_ch] : 10'h000;
  assign rd_valid = valid_reg[rd_ch];
endmodule // result_bank

// *** src/adc_result_validity_control.v ***
// Converter control with APB registers, result validity and interrupt
// Function
// - Channel-select writes never clear the conversion-end flag.
// - A conversion in flight finishes for the old channel and sets the flag.
// - Mode or select writes may spoil results; software reads results first.
// - Deepest stop halts conversion; results around it are invalid.
// - First two conversions after stop release are invalid.
// - Idle modes keep converting; clearing enable stops them.
// - First conversion after idle release is invalid; earlier results stay valid.
// - Each result is a 10-bit code of 1024 steps.
// - Conversion time runs from trigger to output and includes sampling.
// - With compare disabled, every conversion in single mode, or of the last channel of a scan, raises the interrupt.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_result_validity_control (
  input wire mclk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [9:0] sample_code,
  output reg [3:0] sample_channel,
  output reg sample_hold,
  output reg converting,
  output reg conversion_end_irq,
  output reg irq
);
  // ==========================================================
  // Registers
  reg [2:0] converter_mode_reg0;
  reg [31:0] converter_mode_reg1;
  reg [17:0] converter_mode_reg2;
  reg [3:0] channel_select_reg;
  reg [1:0] status_reg;
  reg [1:0] mask_reg;
  reg [1:0] stby_reg;
  reg [3:0] cur_ch_reg;
  reg [1:0] discard_reg;
  reg stale_reg;
  reg [2:0] state_reg;
  localparam S_IDLE = 3'h0;
  localparam S_CONV = 3'h1;
  localparam S_STOP = 3'h2;

  function is_result;
    input [11:0] a;
    begin
      is_result = (a >= `OFS_RESULT) && (a <= `OFS_RESULT_END) && (a[1:0] == 2'h0);
    end
  endfunction

  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready;
  wire wr_mode = wr_acc && (paddr == `OFS_MODE0 || paddr == `OFS_MODE1 ||
    paddr == `OFS_MODE2);
  wire wr_sel = wr_acc && (paddr == `OFS_CHSEL);
  wire ce = converter_mode_reg0[`BIT_CE];
  wire in_stop = stby_reg[`STBY_STOP];
  wire in_idle = stby_reg[`STBY_IDLE];

  // ==========================================================
  // Conversion timing and result storage
  wire t_sampling;
  wire t_busy;
  wire t_done;
  wire start = (state_reg == S_IDLE) && ce && !in_stop;
  wire abort = in_stop || !ce;
  conv_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(start),
    .abort(abort),
    .sampling(t_sampling),
    .busy(t_busy),
    .done(t_done)
  );
  wire [9:0] rb_data;
  wire rb_valid;
  wire res_ok = (discard_reg == 2'h0) && !stale_reg;
  result_bank u_bank (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(t_done),
    .wr_ch(cur_ch_reg),
    .wr_data(sample_code),
    .wr_valid(res_ok),
    .rd_ch(paddr[5:2]),
    .rd_data(rb_data),
    .rd_valid(rb_valid)
  );
  wire [9:0] thr = converter_mode_reg2[`THR_LSB+9:`THR_LSB];
  wire cmp_hit = converter_mode_reg2[`BIT_PFC] ? (sample_code < thr) : (sample_code >= thr);
  wire last_ch = !converter_mode_reg0[`BIT_SCAN] || (cur_ch_reg == channel_select_reg);
  wire end_evt = t_done && last_ch &&
    (!converter_mode_reg2[`BIT_PFE] || cmp_hit);

  // ==========================================================
  // Sequencer
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cur_ch_reg <= 4'h0;
      discard_reg <= 2'h0;
      stale_reg <= 1'b0;
    end else begin
      if (wr_mode || wr_sel)
        stale_reg <= t_busy;
      else if (t_done)
        stale_reg <= 1'b0;
      if (in_stop)
        discard_reg <= `DISCARD_STOP;
      else if (wr_acc && paddr == `OFS_STBY && in_idle && !pwdata[`STBY_IDLE])
        discard_reg <= `DISCARD_IDLE;
      else if (t_done && discard_reg != 2'h0)
        discard_reg <= discard_reg - 2'h1;
      case (state_reg)
        S_IDLE: begin
          if (in_stop)
            state_reg <= S_STOP;
          else if (ce) begin
            state_reg <= S_CONV;
            cur_ch_reg <= converter_mode_reg0[`BIT_SCAN] ? 4'h0 : channel_select_reg;
          end
        end
        S_CONV: begin
          if (in_stop)
            state_reg <= S_STOP;
          else if (!ce)
            state_reg <= S_IDLE;
          else if (t_done) begin
            if (!last_ch)
              cur_ch_reg <= cur_ch_reg + 4'h1;
            else if (converter_mode_reg0[`BIT_CONT])
              cur_ch_reg <= converter_mode_reg0[`BIT_SCAN] ? 4'h0 : channel_select_reg;
            if (last_ch && !converter_mode_reg0[`BIT_CONT])
              state_reg <= S_STOP;
            else
              state_reg <= S_IDLE;
          end
        end
        S_STOP: begin
          if (!in_stop && !ce)
            state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // APB slave
  always @(posedge mclk) begin
    if (!rst_n) begin
      converter_mode_reg0 <= 3'h0;
      converter_mode_reg1 <= 32'h0;
      converter_mode_reg2 <= 18'h0;
      channel_select_reg <= 4'h0;
      status_reg <= 2'h0;
      mask_reg <= 2'h0;
      stby_reg <= 2'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        pslverr <= !(paddr == `OFS_MODE0 || paddr == `OFS_MODE1 ||
          paddr == `OFS_MODE2 || paddr == `OFS_CHSEL || paddr == `OFS_STATUS ||
          paddr == `OFS_MASK || paddr == `OFS_STBY || is_result(paddr));
        case (paddr)
          `OFS_MODE0: prdata <= {29'h0, converter_mode_reg0};
          `OFS_MODE1: prdata <= converter_mode_reg1;
          `OFS_MODE2: prdata <= {14'h0, converter_mode_reg2};
          `OFS_CHSEL: prdata <= {28'h0, channel_select_reg};
          `OFS_STATUS: prdata <= {30'h0, status_reg};
          `OFS_MASK: prdata <= {30'h0, mask_reg};
          `OFS_STBY: prdata <= {30'h0, stby_reg};
          default: prdata <= 32'h0;
        endcase
      end
      if (setup && is_result(paddr))
        prdata <= {21'h0, rb_valid, rb_data};
      if (wr_acc) begin
        case (paddr)
          `OFS_MODE0: converter_mode_reg0 <= pwdata[2:0];
          `OFS_MODE1: converter_mode_reg1 <= pwdata;
          `OFS_MODE2: converter_mode_reg2 <= pwdata[17:0];
          `OFS_CHSEL: channel_select_reg <= pwdata[3:0];
          `OFS_MASK: mask_reg <= pwdata[1:0];
          `OFS_STBY: stby_reg <= pwdata[1:0];
          default: ;
        endcase
      end
      // Set wins over write-one clear
      status_reg[`ST_END] <= end_evt ||
        (status_reg[`ST_END] && !(wr_acc && paddr == `OFS_STATUS && pwdata[`ST_END]));
      status_reg[`ST_INVAL] <= (t_done && !res_ok) ||
        (status_reg[`ST_INVAL] && !(wr_acc && paddr == `OFS_STATUS && pwdata[`ST_INVAL]));
    end
  end

  // ==========================================================
  // Outputs
  always @(posedge mclk) begin
    if (!rst_n) begin
      sample_channel <= 4'h0;
      sample_hold <= 1'b0;
      converting <= 1'b0;
      conversion_end_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      sample_channel <= cur_ch_reg;
      sample_hold <= t_sampling;
      converting <= t_busy;
      conversion_end_irq <= end_evt;
      irq <= |(status_reg & mask_reg);
    end
  end
endmodule // adc_result_validity_control

// *** testbench/adc_ctrl_props.sv ***
// Port assertions for the converter control block
`timescale 1ns/1ps
module adc_ctrl_props (
  input wire mclk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [9:0] sample_code,
  input wire [3:0] sample_channel,
  input wire sample_hold,
  input wire converting,
  input wire conversion_end_irq,
  input wire irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Bus
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h07c |=> pslverr)
    else $error("unmapped not refused");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 12'h07c
    |=> prdata == 32'h0) else $error("unmapped read not zero");
  // ==========
  // Conversion
  a_sample_len: assert property ($rose(sample_hold) |-> sample_hold [*8] ##1 !sample_hold)
    else $error("sampling length wrong");
  a_conv_time: assert property ($rose(sample_hold) |-> ##[36:44] conversion_end_irq)
    else $error("conversion end late");
  a_end_pulse: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("end event too long");
  a_chan_stable: assert property (sample_hold && $past(sample_hold)
    |-> $stable(sample_channel)) else $error("channel moved in sampling");
  c_end: cover property (conversion_end_irq);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule // adc_ctrl_props

// *** testbench/testbench.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
  reg mclk, rst_n, psel, penable, pwrite, last_err;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [9:0] sample_code;
  wire [31:0] prdata;
  wire [3:0] sample_channel;
  wire pready, pslverr, sample_hold, converting, conversion_end_irq, irq;
  integer n_errors, cmp_count;
  adc_result_validity_control dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_code(sample_code), .sample_channel(sample_channel),
    .sample_hold(sample_hold), .converting(converting),
    .conversion_end_irq(conversion_end_irq), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task conclude;
    begin
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count++;
      if (g !== e) begin
        n_errors++;
        $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task chk1(input string nm, input e, input g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // ==========
  // Bus access
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge mclk); i++; end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin n_errors++; conclude; end
      rd = prdata; last_err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task wait_end;
    integer i;
    begin
      i = 0;
      do begin @(posedge mclk); i++; end while (conversion_end_irq !== 1'b1 && i < 100);
      if (conversion_end_irq !== 1'b1) begin n_errors++; conclude; end
    end
  endtask
  task conv(input [3:0] ch, input [9:0] code, input ok);
    begin
      sample_code <= code;
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h00c, {28'h0, ch});
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b1, 12'h000, 32'h1);
      wait_end;
      chk("channel", {28'h0, ch}, {28'h0, sample_channel});
      apb(1'b0, 12'h040 + {6'h0, ch, 2'b00}, 32'h0);
      chk("result", ok ? {21'h0, 1'b1, code} : 32'h0, rd);
    end
  endtask
  // ==========
  // Sequence
  initial begin
    n_errors = 0; cmp_count = 0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; sample_code = 10'h0; rd = 32'h0; last_err = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, 12'h010, 32'h0); chk("status", 32'h0, rd);
    apb(1'b0, 12'h080, 32'h0); chk("unmapped", 32'h0, rd); chk1("slverr", 1'b1, last_err);
    $display("test reset done");
    apb(1'b1, 12'h014, 32'h1);
    conv(4'h3, 10'h2a5, 1'b1);
    chk1("irq", 1'b1, irq);
    apb(1'b1, 12'h00c, 32'h5); apb(1'b0, 12'h010, 32'h0); chk1("flag", 1'b1, rd[0]);
    apb(1'b1, 12'h014, 32'h0); apb(1'b0, 12'h014, 32'h0); chk1("irq masked", 1'b0, irq);
    apb(1'b1, 12'h014, 32'h1); apb(1'b0, 12'h014, 32'h0); chk1("irq on", 1'b1, irq);
    apb(1'b1, 12'h010, 32'h3); apb(1'b0, 12'h010, 32'h0); chk1("cleared", 1'b0, rd[0]);
    chk1("irq off", 1'b0, irq);
    apb(1'b1, 12'h000, 32'h0); apb(1'b1, 12'h00c, 32'h2); apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h00c, 32'h4); wait_end;
    apb(1'b0, 12'h010, 32'h0); chk1("old flag", 1'b1, rd[0]);
    apb(1'b0, 12'h048, 32'h0); chk("spoiled", 32'h0, rd);
    apb(1'b1, 12'h010, 32'h3);
    $display("test flag done");
    apb(1'b1, 12'h000, 32'h0); apb(1'b1, 12'h018, 32'h1);
    chk1("stopped", 1'b0, converting);
    apb(1'b1, 12'h018, 32'h0);
    conv(4'h6, 10'h155, 1'b0);
    conv(4'h6, 10'h0aa, 1'b0);
    conv(4'h6, 10'h155, 1'b1);
    $display("test stop done");
    apb(1'b1, 12'h000, 32'h0); apb(1'b1, 12'h018, 32'h2); apb(1'b1, 12'h018, 32'h0);
    conv(4'h9, 10'h3ff, 1'b0);
    apb(1'b0, 12'h058, 32'h0); chk("kept", {21'h0, 1'b1, 10'h155}, rd);
    conv(4'h9, 10'h3ff, 1'b1);
    $display("test idle done");
    conclude;
  end
endmodule // testbench
bind adc_result_validity_control adc_ctrl_props u_props (.mclk(mclk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_code(sample_code),
  .sample_channel(sample_channel), .sample_hold(sample_hold), .converting(converting),
  .conversion_end_irq(conversion_end_irq), .irq(irq));
